/* File: verilog/swpp_pkg.sv */
// Purpose: constants for the host-side write controller of a battery-backed SRAM
// Assumes: 10 MHz clock, 100 ns period
// Notes: times kept in their own units, cycle counts derived
package swpp_pkg;
  localparam int CLK_NS = 100;
  localparam int LOC_W = 15;
  localparam int BYTE_W = 8;
  // Write timing in ns
  localparam int T_CYCLE_NS = 70;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_CS_PULSE_NS = 55;
  localparam int T_DATA_SETUP_NS = 30;
  localparam int T_DATA_HOLD_NS = 5;
  localparam int T_LOC_SETUP_NS = 60;
  localparam int T_DRIVE_OFF_NS = 25;
  localparam int T_RECOVERY_NS = 5;
  // Least times round up
  localparam int WE_PULSE_CYC = (T_WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF_CYC = (T_DRIVE_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC = (T_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  // Power-up holdoff, worst case 200 ms
  localparam int T_HOLDOFF_MS = 200;
  localparam int HOLDOFF_CYC = T_HOLDOFF_MS * (1000000 / CLK_NS);
  // Slow-fall late deselect, 200 us
  localparam int T_LATE_US = 200;
  localparam int LATE_CYC = T_LATE_US * (1000 / CLK_NS);
  localparam logic [1:0] SUPPLY_NORMAL = 2'h0;
  localparam logic [1:0] SUPPLY_DESELECT = 2'h1;
  localparam logic [1:0] SUPPLY_BATTERY = 2'h2;
endpackage : swpp_pkg

/* File: verilog/swpp_gate_if.sv */
// Purpose: carries supply gating between the write controller and its guard
// Assumes: single clock domain
// Notes: guard drives ready, controller reads it
`timescale 1ns/1ns
interface swpp_gate_if;
  logic ready;
  logic fail;
  modport guard (output ready, output fail);
  modport ctrl (input ready, input fail);
endinterface : swpp_gate_if

/* File: verilog/swpp_guard.sv */
// Purpose: supply guard, allows bus activity only after power-up holdoff
// Assumes: supply level from an external monitor, asynchronous
// Notes: holdoff count is a parameter so simulation may shorten it
`timescale 1ns/1ns
module swpp_guard
  import swpp_pkg::*;
#(
  parameter int HOLDOFF = HOLDOFF_CYC,
  parameter int LATE = LATE_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_supply,
  swpp_gate_if.guard gate
);
  if (HOLDOFF < 1 || LATE < 1)
  begin : g_bad_count
    $error("swpp_guard: counts must be positive");
  end
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [31:0] cnt_q;
  logic ready_q;
  logic fail_q;
  wire normal = (s2_q == SUPPLY_NORMAL);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_q <= SUPPLY_BATTERY;
      s2_q <= SUPPLY_BATTERY;
      cnt_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      fail_q <= 1'b1;
    end
    else
    begin
      s1_q <= i_supply;
      s2_q <= s1_q;
      fail_q <= !normal;
      if (!normal)
      begin
        cnt_q <= 32'h0000_0000;
        ready_q <= 1'b0;
      end
      else if (cnt_q < 32'(HOLDOFF))
        cnt_q <= cnt_q + 32'h0000_0001;
      else
        ready_q <= 1'b1;
    end
  end
  assign gate.ready = ready_q;
  assign gate.fail = fail_q;
endmodule : swpp_guard

/* File: verilog/swpp_host.sv */
// How it works
// - location held stable through write
// - strobe high recovery before next access
// - data setup 30 ns, hold 5 ns
// - output enable high during writes
// - write cycle at least 70 ns
// - write strobe low at least 50 ns
// - chip select low at least 55 ns
// - location valid 60 ns before end
// - chip select high while supply rises
// Purpose: host bus master issuing strobe-controlled writes to the SRAM
// Assumes: pins are registered, 100 ns clock, one write at a time
// Notes: chip select falls first, write strobe later; strobe ends the write
`timescale 1ns/1ns
module swpp_host
  import swpp_pkg::*;
#(
  parameter int HOLDOFF = HOLDOFF_CYC,
  parameter int LATE = LATE_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_supply,
  input wire logic i_req,
  input wire logic [LOC_W-1:0] i_loc,
  input wire logic [BYTE_W-1:0] i_data,
  output logic o_busy,
  output logic o_done,
  output logic o_blocked,
  output logic o_cs_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [LOC_W-1:0] o_location_bus,
  output logic [BYTE_W-1:0] o_byte_lines,
  output logic o_byte_lines_oe
);
  // Counter load for a span of cyc cycles
  function automatic logic [3:0] load_of(input int cyc);
    return 4'(cyc - 1);
  endfunction : load_of

  if (WE_PULSE_CYC < 1 || CYCLE_CYC < 1 || HOLD_CYC < 1 || REC_CYC < 1)
  begin : g_short_span
    $error("swpp_host: every span needs at least one cycle");
  end
  if (WE_PULSE_CYC > 16 || CYCLE_CYC > 16 || HOLD_CYC > 16 || REC_CYC > 16)
  begin : g_long_span
    $error("swpp_host: spans beyond 16 cycles overflow the counter");
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_REC = 5'b10000
  } swpp_state_t;
  swpp_gate_if gate ();
  swpp_guard #(.HOLDOFF(HOLDOFF), .LATE(LATE)) u_guard (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_supply(i_supply),
    .gate(gate)
  );
  swpp_state_t st_q;
  swpp_state_t st_d;
  logic [3:0] cnt_q;
  logic cs_n_q;
  logic we_n_q;
  logic [LOC_W-1:0] loc_q;
  logic [BYTE_W-1:0] dat_q;
  logic doe_q;
  logic done_q;
  logic blk_q;
  logic [3:0] cnt_d;
  logic oe_n_q;
  logic busy_q;

  wire cnt_zero = (cnt_q == 4'h0);
  wire start = i_req && gate.ready && !gate.fail;
  wire take = (st_q == ST_IDLE) && start;
  wire arm = (st_q == ST_SETUP);
  wire lift = (st_q == ST_STROBE) && cnt_zero;
  wire cs_end = (st_q == ST_HOLD) && cnt_zero;
  wire rec_end = (st_q == ST_REC) && cnt_zero;
  wire [3:0] strobe_load = load_of(WE_PULSE_CYC > CYCLE_CYC ? WE_PULSE_CYC : CYCLE_CYC);
  wire [3:0] hold_load = load_of(HOLD_CYC);
  wire [3:0] rec_load = load_of(REC_CYC);

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (start) st_d = ST_SETUP;
      ST_SETUP: st_d = ST_STROBE;
      ST_STROBE: if (cnt_zero) st_d = ST_HOLD;
      ST_HOLD: if (cnt_zero) st_d = ST_REC;
      ST_REC: if (cnt_zero) st_d = ST_IDLE;
    endcase
  end
  // Span counter, reloaded on entry to strobe, hold and recovery
  always_comb
  begin
    cnt_d = cnt_zero ? cnt_q : cnt_q - 4'h1;
    if (arm)
      cnt_d = strobe_load;
    else if (lift)
      cnt_d = hold_load;
    else if (cs_end)
      cnt_d = rec_load;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      busy_q <= (st_d != ST_IDLE);
    end
  end

  // Select leads the strobe by a cycle, so strobe edges bound the write
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cs_n_q <= 1'b1;
    else if (take)
      cs_n_q <= 1'b0;
    else if (cs_end)
      cs_n_q <= 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      we_n_q <= 1'b1;
    else if (arm)
      we_n_q <= 1'b0;
    else if (lift)
      we_n_q <= 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      oe_n_q <= 1'b1;
    else
      oe_n_q <= 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      loc_q <= '0;
    else if (take)
      loc_q <= i_loc;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      dat_q <= '0;
    else if (take)
      dat_q <= i_data;
  end
  // Data stays driven a cycle past the strobe rise for hold
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      doe_q <= 1'b0;
    else if (take)
      doe_q <= 1'b1;
    else if (cs_end)
      doe_q <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      done_q <= 1'b0;
    else
      done_q <= rec_end;
  end
  // Status only, one cycle behind the guard
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      blk_q <= 1'b1;
    else
      blk_q <= !gate.ready;
  end

  assign o_cs_n = cs_n_q;
  assign o_we_n = we_n_q;
  assign o_oe_n = oe_n_q;
  assign o_location_bus = loc_q;
  assign o_byte_lines = dat_q;
  assign o_byte_lines_oe = doe_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_blocked = blk_q;
endmodule : swpp_host

/* File: tb/swpp_monitor.sv */
// Purpose: pin checks
// Assumes: host ports
// Notes: bound below
`timescale 1ns/1ns
module swpp_monitor
  import swpp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [LOC_W-1:0] i_loc,
  input wire logic [BYTE_W-1:0] i_data,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_blocked,
  input wire logic o_cs_n,
  input wire logic o_we_n,
  input wire logic o_oe_n,
  input wire logic [LOC_W-1:0] o_location_bus,
  input wire logic [BYTE_W-1:0] o_byte_lines,
  input wire logic o_byte_lines_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_pins;
    !o_cs_n ##1 !o_we_n ##1 o_we_n && !o_cs_n ##1 o_cs_n ##1 o_done ##1 !o_busy;
  endsequence
  chk_oe_high: assert property (o_oe_n) else $error("oe");
  chk_take_req: assert property (i_req && !o_busy ##1 !o_blocked |-> o_busy && o_location_bus == $past(i_loc)
    && o_byte_lines == $past(i_data)) else $error("take");
  chk_write_walk: assert property ($fell(o_cs_n) |-> s_pins) else $error("walk");
  chk_we_in_cs: assert property (!o_we_n |-> $past(!o_cs_n) && !o_cs_n) else $error("we");
  chk_loc_held: assert property (!o_cs_n && $past(!o_cs_n) |-> $stable(o_location_bus)
    && $stable(o_byte_lines)) else $error("hold");
  chk_drive_span: assert property (o_byte_lines_oe == !o_cs_n) else $error("drv");
  chk_blocked_idle: assert property (o_blocked && !o_busy ##1 o_blocked |-> o_cs_n && !o_busy) else $error("blk");
  chk_done_pulse: assert property (o_done |=> !o_done && !o_busy) else $error("done");
endmodule : swpp_monitor
bind swpp_host swpp_monitor u_mon (.*);

/* File: tb/swpp_sram_model.sv */
// Purpose: SRAM model
// Assumes: supply 0 is normal
// Notes: clockless
`timescale 1ns/1ns
module swpp_sram_model
  import swpp_pkg::*;
(
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [1:0] i_supply,
  input wire logic [LOC_W-1:0] i_loc,
  input wire logic [BYTE_W-1:0] i_dq,
  output logic [BYTE_W-1:0] o_dq,
  output logic o_dq_oe
);
  logic [BYTE_W-1:0] mem [0:32767];
  wire live = i_supply == SUPPLY_NORMAL;
  always @(posedge i_we_n or posedge i_cs_n)
    if (live && !(i_we_n && i_cs_n)) mem[i_loc] = i_dq;
  assign #5 o_dq_oe = live && !i_cs_n && !i_oe_n && i_we_n;
  assign o_dq = mem[i_loc];
endmodule : swpp_sram_model

/* File: tb/testbench.sv */
// Purpose: host bench
// Assumes: holdoff 20
// Notes: random writes, power fail
`timescale 1ns/1ns
module testbench;
  import swpp_pkg::*;
  localparam int HO = 20;
  logic i_clk, i_rst_n, i_req, busy, done, blk, cs_n, we_n, oe_n, h_oe, d_oe;
  logic [1:0] i_supply;
  logic [LOC_W-1:0] i_loc, loc, ra;
  logic [BYTE_W-1:0] i_data, hq, d_q, dq, rd;
  int errors, checks, seed, n;
  swpp_host #(.HOLDOFF(HO), .LATE(20)) u_swpp_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply(i_supply),
    .i_req(i_req), .i_loc(i_loc), .i_data(i_data), .o_busy(busy), .o_done(done), .o_blocked(blk),
    .o_cs_n(cs_n), .o_we_n(we_n), .o_oe_n(oe_n), .o_location_bus(loc), .o_byte_lines(hq),
    .o_byte_lines_oe(h_oe));
  assign dq = h_oe ? hq : d_oe ? d_q : ~hq;
  swpp_sram_model u_swpp_sram_model (.i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_supply(i_supply),
    .i_loc(loc), .i_dq(dq), .o_dq(d_q), .o_dq_oe(d_oe));
  initial
  begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end
  function automatic logic [7:0] in_win(input int c);
    return {7'h0, c >= HO && c <= HO + 6};
  endfunction : in_win
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wait_ready;
    n = 0;
    while (blk !== 1'b0 && n < HO + 9)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    chk("holdoff", 8'h1, in_win(n));
    if (blk !== 1'b0)
      wrap_up();
  endtask : wait_ready
  task automatic wr(input logic [LOC_W-1:0] a, input logic [7:0] d, input int fail_at);
    @(posedge i_clk);
    #1 {i_req, i_loc, i_data} = {1'b1, a, d};
    @(posedge i_clk);
    #1 {i_req, i_loc, i_data} = {1'b0, LOC_W'($random(seed)), 8'($random(seed))};
    n = 0;
    while (done !== 1'b1 && n < 10)
    begin
      if (n == fail_at) i_supply = SUPPLY_DESELECT;
      @(posedge i_clk);
      #1 n++;
    end
    if (done !== 1'b1)
    begin
      chk("done", 8'h1, {7'h0, done});
      wrap_up();
    end
  endtask : wr
  initial
  begin
    seed = 32'hbf9b_fef5;
    {errors, checks, i_rst_n, i_req, i_loc, i_data, i_supply} = 0;
    repeat (5) @(posedge i_clk);
    #1 i_rst_n = 1;
    wait_ready();
    wr(15'h7fff, 8'h81, 99);
    chk("top", 8'h81, u_swpp_sram_model.mem[15'h7fff]);
    for (int k = 0; k < 24; k++)
    begin
      {ra, rd} = 23'($random(seed));
      wr(ra, rd, 99);
      chk("byte", rd, u_swpp_sram_model.mem[ra]);
    end
    wr(15'h0000, 8'h3c, 99);
    wr(15'h0001, 8'hc3, 1);
    chk("kept", 8'h3c, u_swpp_sram_model.mem[0]);
    i_req = 1;
    repeat (4) @(posedge i_clk);
    #1 chk("blocked", 8'h1, {7'h0, blk});
    chk("refused", 8'h0, {7'h0, busy});
    {i_req, i_supply} = {1'b0, SUPPLY_BATTERY};
    repeat (3) @(posedge i_clk);
    #1 i_supply = SUPPLY_NORMAL;
    wait_ready();
    wr(15'h0001, 8'h5a, 99);
    chk("again", 8'h5a, u_swpp_sram_model.mem[1]);
    wrap_up();
  end
endmodule : testbench
